// ==== shared/tmof_defs.vh ====
// register offsets, field positions and reset values of the timer flag block
`ifndef TMOF_DEFS_VH
`define TMOF_DEFS_VH
`define TMOF_ADDR_W 4
`define TMOF_OFS_BMATCH 4'h0
`define TMOF_OFS_WRAP 4'h4
`define TMOF_OFS_STANDBY 4'h8
`define TMOF_BMATCH_RST 8'h88
`define TMOF_WRAP_RST 8'h88
`define TMOF_RSVD_MASK_B 8'h88
`define TMOF_RSVD_MASK_W 8'h88
`define TMOF_FLAG_LSB 0
`define TMOF_EN_LSB 4
`define TMOF_RESP_OKAY 2'b00
`define TMOF_RESP_SLVERR 2'b10
`endif

// ==== core/tmof_top.v ====
// flag and enable registers for the three-channel timer, axi4-lite slave
`timescale 1ns/100ps
`include "tmof_defs.vh"
// What this block does
// - ch1 b-match request gated by enable bit5
// - ch0 b-match request gated by enable bit4
// - ch2 b-match request gated by enable bit6
// - b register bit3 reads one, ignores writes
// - ch2 b flag set on compare match
// - ch2 b flag set on input capture
// - ch1 b flag set on match or capture
// - ch0 b flag set on match or capture
// - flag clears after read-one then write-zero
// - writing one to a flag changes nothing
// - wrap register resets to 88 on reset, standby
// - wrap register bits 7 and 3 read one
// - ch2 wrap request gated by enable bit6
// - ch1 wrap request gated by enable bit5
// - ch0 wrap request gated by enable bit4
// - ch2 wrap flag on overflow or underflow
// - underflow only on ch2 in phase counting
// - ch1 wrap flag on overflow
// - ch0 wrap flag on overflow
// - b register resets to 88 on reset, standby
module tmof_top (
  input wire ref_clk_i, // 50 MHz timer clock
  input wire sys_rst_i, // async reset, active high
  input wire standby_i, // standby entry, reinitialises registers
  input wire [2:0] b_compare_match_i, // counter equals second general reg, per channel
  input wire [2:0] b_capture_i, // capture into second general reg, per channel
  input wire [2:0] b_is_capture_i, // 1: second general reg in capture use
  input wire [2:0] overflow_i, // counter wrapped all ones to zero
  input wire underflow_ch2_i, // channel 2 wrapped zero to all ones
  input wire phase_count_select_i, // channel 2 phase counting mode
  input wire [3:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [3:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  output wire b_match_irq_ch0_o,
  output wire b_match_irq_ch1_o,
  output wire b_match_irq_ch2_o,
  output wire wrap_irq_ch0_o,
  output wire wrap_irq_ch1_o,
  output wire wrap_irq_ch2_o
);
  reg [2:0] b_flag_reg; // b-match flags ch2..ch0
  reg [2:0] b_en_reg; // b-match enables ch2..ch0
  reg [2:0] w_flag_reg; // wrap flags ch2..ch0
  reg [2:0] w_en_reg; // wrap enables ch2..ch0
  reg [2:0] b_armed_reg; // flags seen as one by a read
  reg [2:0] w_armed_reg;
  reg standby_reg; // software standby request
  reg aw_held_reg; // write address captured
  reg w_held_reg; // write data captured
  reg [3:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire [2:0] b_set; // b flag set events
  wire [2:0] w_set; // wrap flag set events
  wire standby_any; // reinitialise from pin or register
  wire wr_go; // write performed this cycle
  wire rd_go; // read accepted this cycle
  wire [7:0] b_view; // b register as read
  wire [7:0] w_view; // wrap register as read
  wire [2:0] b_clr; // b flags cleared this cycle
  wire [2:0] w_clr;
  wire wr_b; // write hits b register
  wire wr_w;
  wire wr_s;

  // match in compare use or capture in capture use
  assign b_set[0] = b_is_capture_i[0] ? b_capture_i[0] : b_compare_match_i[0];
  assign b_set[1] = b_is_capture_i[1] ? b_capture_i[1] : b_compare_match_i[1];
  assign b_set[2] = b_is_capture_i[2] ? b_capture_i[2] : b_compare_match_i[2];
  // overflow on every channel, underflow only in phase counting
  assign w_set[0] = overflow_i[0];
  assign w_set[1] = overflow_i[1];
  assign w_set[2] = overflow_i[2] | (underflow_ch2_i & phase_count_select_i);

  assign standby_any = standby_i | standby_reg;
  // reserved bits forced to one
  assign b_view = {1'b1, b_en_reg, 1'b1, b_flag_reg};
  assign w_view = {1'b1, w_en_reg, 1'b1, w_flag_reg};

  // write channel handshake, address and data in either order
  assign s_axi_awready_o = ~aw_held_reg & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_held_reg & ~s_axi_bvalid_o;
  assign wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
  assign wr_b = wr_go & (awaddr_reg == `TMOF_OFS_BMATCH) & wstrb_reg[0];
  assign wr_w = wr_go & (awaddr_reg == `TMOF_OFS_WRAP) & wstrb_reg[0];
  assign wr_s = wr_go & (awaddr_reg == `TMOF_OFS_STANDBY) & wstrb_reg[0];
  // clear only armed flags written with zero; ones leave flags alone
  assign b_clr = wr_b ? (b_armed_reg & ~wdata_reg[2:0]) : 3'h0;
  assign w_clr = wr_w ? (w_armed_reg & ~wdata_reg[2:0]) : 3'h0;

  // read handshake
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign rd_go = s_axi_arvalid_i & s_axi_arready_o;

  // interrupt requests, level while flag and enable are one
  assign b_match_irq_ch0_o = b_flag_reg[0] & b_en_reg[0];
  assign b_match_irq_ch1_o = b_flag_reg[1] & b_en_reg[1];
  assign b_match_irq_ch2_o = b_flag_reg[2] & b_en_reg[2];
  assign wrap_irq_ch0_o = w_flag_reg[0] & w_en_reg[0];
  assign wrap_irq_ch1_o = w_flag_reg[1] & w_en_reg[1];
  assign wrap_irq_ch2_o = w_flag_reg[2] & w_en_reg[2];

  // write address and data capture, response
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `TMOF_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        // response once both halves are in
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        if ((awaddr_reg == `TMOF_OFS_BMATCH) | (awaddr_reg == `TMOF_OFS_WRAP) |
            (awaddr_reg == `TMOF_OFS_STANDBY)) begin
          s_axi_bresp_o <= `TMOF_RESP_OKAY;
        end else begin
          s_axi_bresp_o <= `TMOF_RESP_SLVERR;
        end
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // read data path
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= `TMOF_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `TMOF_RESP_OKAY;
      case (s_axi_araddr_i)
        `TMOF_OFS_BMATCH: s_axi_rdata_o <= {24'h0, b_view};
        `TMOF_OFS_WRAP: s_axi_rdata_o <= {24'h0, w_view};
        `TMOF_OFS_STANDBY: s_axi_rdata_o <= {31'h0, standby_reg};
        default: begin
          // unmapped address
          s_axi_rdata_o <= 32'h0;
          s_axi_rresp_o <= `TMOF_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o & s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // standby control register
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      standby_reg <= 1'b0;
    end else if (wr_s) begin
      standby_reg <= wdata_reg[0];
    end
  end

  // flags, enables and read arming; set beats clear
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      b_flag_reg <= 3'h0;
      b_en_reg <= 3'h0;
      w_flag_reg <= 3'h0;
      w_en_reg <= 3'h0;
      b_armed_reg <= 3'h0;
      w_armed_reg <= 3'h0;
    end else if (standby_any) begin
      // standby reinitialises both registers
      b_flag_reg <= 3'h0;
      b_en_reg <= 3'h0;
      w_flag_reg <= 3'h0;
      w_en_reg <= 3'h0;
      b_armed_reg <= 3'h0;
      w_armed_reg <= 3'h0;
    end else begin
      b_flag_reg <= (b_flag_reg & ~b_clr) | b_set;
      w_flag_reg <= (w_flag_reg & ~w_clr) | w_set;
      if (wr_b) begin
        b_en_reg <= wdata_reg[6:4];
      end
      if (wr_w) begin
        w_en_reg <= wdata_reg[6:4];
      end
      // a read arms flags that were one; a write disarms
      if (rd_go & (s_axi_araddr_i == `TMOF_OFS_BMATCH)) begin
        b_armed_reg <= b_armed_reg | b_flag_reg;
      end else if (wr_b) begin
        b_armed_reg <= 3'h0;
      end
      if (rd_go & (s_axi_araddr_i == `TMOF_OFS_WRAP)) begin
        w_armed_reg <= w_armed_reg | w_flag_reg;
      end else if (wr_w) begin
        w_armed_reg <= 3'h0;
      end
    end
  end
endmodule

// ==== tb/tmof_chk_assertions.sv ====
// assertions on the interrupt outputs of the timer flag block
`timescale 1ns/100ps
module tmof_chk (
  input wire ref_clk_i, sys_rst_i, standby_i, underflow_ch2_i,
  input wire phase_count_select_i, s_axi_bvalid_o,
  input wire [2:0] b_compare_match_i, b_capture_i, b_is_capture_i, overflow_i,
  input wire b_match_irq_ch0_o, b_match_irq_ch1_o, b_match_irq_ch2_o,
  input wire wrap_irq_ch0_o, wrap_irq_ch1_o, wrap_irq_ch2_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // irq lines grouped per register
  wire [2:0] bi = {b_match_irq_ch2_o, b_match_irq_ch1_o, b_match_irq_ch0_o};
  wire [2:0] wi = {wrap_irq_ch2_o, wrap_irq_ch1_o, wrap_irq_ch0_o};
  // events that may set a flag in the current mode
  wire [2:0] hit = b_is_capture_i & b_capture_i | ~b_is_capture_i & b_compare_match_i;
  wire [2:0] ovf = {overflow_i[2] | underflow_ch2_i & phase_count_select_i, overflow_i[1:0]};
  property p_sb; standby_i |=> {bi, wi} == 6'h0; endproperty
  a_sb: assert property (p_sb) else $error("irq after standby");
  property p_w0; $rose(wi[0]) |-> $past(ovf[0]) || $rose(s_axi_bvalid_o); endproperty
  a_w0: assert property (p_w0) else $error("w0 cause");
  property p_w1; $rose(wi[1]) |-> $past(ovf[1]) || $rose(s_axi_bvalid_o); endproperty
  a_w1: assert property (p_w1) else $error("w1 cause");
  property p_w2; $rose(wi[2]) |-> $past(ovf[2]) || $rose(s_axi_bvalid_o); endproperty
  a_w2: assert property (p_w2) else $error("w2 cause");
  property p_b0; $rose(bi[0]) |-> $past(hit[0]) || $rose(s_axi_bvalid_o); endproperty
  a_b0: assert property (p_b0) else $error("b0 cause");
  property p_b1; $rose(bi[1]) |-> $past(hit[1]) || $rose(s_axi_bvalid_o); endproperty
  a_b1: assert property (p_b1) else $error("b1 cause");
  property p_b2; $rose(bi[2]) |-> $past(hit[2]) || $rose(s_axi_bvalid_o); endproperty
  a_b2: assert property (p_b2) else $error("b2 cause");
  property p_fl; $fell(wi[0]) |-> $rose(s_axi_bvalid_o) || $past(standby_i); endproperty
  a_fl: assert property (p_fl) else $error("w0 dropped");
endmodule
bind tmof_top tmof_chk tmof_chk_i (.*);

// ==== tb/test_timer_match_overflow_flags.sv ====
// self-checking bench for the timer flag block
`timescale 1ns/100ps
module test_timer_match_overflow_flags;
  reg ref_clk_i = 0, sys_rst_i = 1, standby_i = 0, underflow_ch2_i = 0;
  reg phase_count_select_i = 0, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
  reg s_axi_arvalid_i = 0, s_axi_bready_i = 1, s_axi_rready_i = 1, k, p;
  reg [2:0] b_compare_match_i = '0, b_capture_i = '0, b_is_capture_i = '0, overflow_i = '0;
  reg [3:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0, s_axi_wstrb_i = 4'hf, a;
  reg [31:0] s_axi_wdata_i = '0;
  reg [2:0] en, m, f;
  wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
  wire [31:0] s_axi_rdata_o;
  wire b_match_irq_ch0_o, b_match_irq_ch1_o, b_match_irq_ch2_o;
  wire wrap_irq_ch0_o, wrap_irq_ch1_o, wrap_irq_ch2_o;
  wire [5:0] irq = {b_match_irq_ch2_o, b_match_irq_ch1_o, b_match_irq_ch0_o,
    wrap_irq_ch2_o, wrap_irq_ch1_o, wrap_irq_ch0_o};
  int mismatches = 0, check_count = 0, n;
  always #10 ref_clk_i = ~ref_clk_i;
  tmof_top tmof_top_i (.*);
  task chk(input [33:0] g, input [33:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // write one register, release each channel when taken
  task wr(input [3:0] ad, input [7:0] d);
    s_axi_awaddr_i <= ad;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (s_axi_bvalid_o !== 1);
    chk({32'h0, s_axi_bresp_o}, {32'h0, (ad == 4'h0 || ad == 4'h4 || ad == 4'h8) ? 2'b00 : 2'b10});
  endtask
  // read one register, compare response and data
  task rd(input [3:0] ad, input [33:0] e);
    s_axi_araddr_i <= ad;
    s_axi_arvalid_i <= 1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (s_axi_rvalid_o !== 1);
    chk({s_axi_rresp_o, s_axi_rdata_o}, e);
  endtask
  // one-cycle events; b channels outside m get only the wrong kind, wrap pulses always give ch2 underflow
  task pulse(input kk, input [2:0] c);
    if (kk) begin
      overflow_i <= m;
      underflow_ch2_i <= 1;
      phase_count_select_i <= p;
    end else begin
      b_is_capture_i <= c;
      b_capture_i <= c & m | ~c & ~m;
      b_compare_match_i <= ~c & m | c & ~m;
    end
    @(posedge ref_clk_i);
    {overflow_i, underflow_ch2_i, b_capture_i, b_compare_match_i} <= '0;
    @(posedge ref_clk_i);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    n = $urandom(32'hc01f);
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    rd(4'h0, 34'h88);
    rd(4'h4, 34'h88);
    rd(4'hc, {2'b10, 32'h0});
    wr(4'hc, 8'h70);
    s_axi_wstrb_i <= 4'h0;
    wr(4'h0, 8'h70);
    s_axi_wstrb_i <= 4'hf;
    rd(4'h0, 34'h88);
    wr(4'h0, 8'hff);
    rd(4'h0, 34'hf8);
    wr(4'h4, 8'h77);
    rd(4'h4, 34'hf8);
    $display("access test done");
    for (n = 0; n < 8; n++) begin
      k = n[0];
      a = {1'b0, n[0], 2'b0};
      en = 3'($urandom);
      m = n < 2 ? 3'h7 : 3'($urandom);
      p = 1'($urandom);
      f = k ? m | {p, 2'b0} : m;
      wr(a, {1'b0, en, 4'h0});
      pulse(k, 3'($urandom));
      chk({28'h0, irq}, {28'h0, k ? {3'h0, en & f} : {en & f, 3'h0}});
      wr(a, {1'b0, en, 4'h7});
      wr(a, {1'b0, en, 4'h0});
      rd(a, {26'h0, 1'b1, en, 1'b1, f});
      wr(a, {1'b0, en, 4'h0});
      rd(a, {26'h0, 1'b1, en, 4'h8});
      chk({28'h0, irq}, 34'h0);
      $display("event test %0d done", n);
    end
    m = 3'h7;
    pulse(0, 3'h5);
    pulse(1, 3'h0);
    standby_i <= 1;
    @(posedge ref_clk_i);
    standby_i <= 0;
    rd(4'h0, 34'h88);
    rd(4'h4, 34'h88);
    wr(4'h8, 8'h01);
    rd(4'h8, 34'h1);
    wr(4'h0, 8'h70);
    rd(4'h0, 34'h88);
    wr(4'h8, 8'h00);
    rd(4'h8, 34'h0);
    $display("standby test done");
    wr(4'h0, 8'h70);
    rd(4'h0, 34'hf8);
    sys_rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    rd(4'h0, 34'h88);
    rd(4'h4, 34'h88);
    $display("reset test done");
    test_done;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    mismatches++;
    test_done;
  end
endmodule
